// [design/dacc_defines.svh]
`ifndef DACC_DEFINES_SVH
`define DACC_DEFINES_SVH
// Register byte offsets
`define DACC_CTRL_OFS 8'h00
`define DACC_DATA_A_OFS 8'h04
`define DACC_DATA_B_OFS 8'h08
`define DACC_STATUS_OFS 8'h0c
`define DACC_IRQ_CLR_OFS 8'h10
`define DACC_IRQ_EN_OFS 8'h14
`define DACC_PRESC_OFS 8'h18
// Field widths and positions
`define DACC_CTRL_W 6
`define DACC_ST_PIN_BIT 8
`define DACC_PSC_SEL_LSB 8
// Reset values
`define DACC_CTRL_RST 6'h00
`define DACC_PSEL_RST 4'h2
`define DACC_CP_RST 8'hff
// Bus answers
`define DACC_RESP_OKAY 2'h0
`define DACC_RESP_SLVERR 2'h2
// Counter bus match to pin change, in clk_sys cycles
`define DACC_CMP_TO_PIN_CYC 3
`endif

// [design/dacc_pkg.sv]
`default_nettype none
package dacc_pkg;
  typedef enum logic [2:0] {
    channel_disabled_mode = 3'h0,
    input_capture_mode = 3'h1,
    input_pulse_width_mode = 3'h3,
    input_period_mode = 3'h2,
    output_compare_mode = 3'h6,
    output_pulse_width_mode = 3'h7
  } dacc_mode_t;

  typedef enum logic [1:0] {
    dacc_act_none = 2'h0,
    dacc_act_to_a = 2'h1,
    dacc_act_shift = 2'h3,
    dacc_act_to_b = 2'h2
  } dacc_act_t;

  typedef struct packed {
    logic [1:0] edge_sel;
    logic out_level;
    dacc_mode_t mode;
  } dacc_ctrl_t;

  typedef struct packed {
    logic [15:0] value;
    logic upd;
  } dacc_cbus_t;
endpackage : dacc_pkg
`default_nettype wire

// [design/dacc_channel.sv]
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`include "dacc_defines.svh"
`default_nettype none
module dacc_channel import dacc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shared counter bus
  input wire dacc_cbus_t cbus,
  // External pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // Prescale settings for the counter units
  output logic [3:0] prescaler_select_field,
  output logic [7:0] channel_prescale_field,
  // Interrupt
  output logic irq
);

  function automatic logic [31:0] dacc_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : dacc_merge

  function automatic logic [31:0] dacc_apply(input dacc_act_t act, input logic [15:0] a,
                                             input logic [15:0] b, input logic [15:0] v);
    logic [31:0] res;
    res = {b, a};
    case (act)
      dacc_act_to_a: res = {b, v};
      dacc_act_to_b: res = {v, a};
      dacc_act_shift: res = {a, v};
      default: res = {b, a};
    endcase
    return res;
  endfunction : dacc_apply

  // Bus slave state
  logic aw_hold_reg, aw_hold_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_hold_reg, w_hold_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_wr;

  // Channel state
  dacc_ctrl_t ctrl_reg, ctrl_next;
  logic [15:0] data_a_reg, data_a_next;
  logic [15:0] data_b_reg, data_b_next;
  logic [1:0] status_reg, status_next;
  logic [1:0] en_reg, en_next;
  logic [3:0] psel_reg, psel_next;
  logic [7:0] cp_reg, cp_next;
  logic sync1_reg, sync2_reg, sync3_reg;
  dacc_cbus_t cb_q_reg;
  dacc_act_t pend_reg, pend_next, act_now;
  logic [`DACC_CMP_TO_PIN_CYC-2:0] ma_pipe_reg, ma_pipe_next;
  logic [`DACC_CMP_TO_PIN_CYC-2:0] mb_pipe_reg, mb_pipe_next;
  logic pin_out_reg, pin_out_next;
  logic pin_chg_reg, pin_chg_next;
  logic pend_pin_v_reg, pend_pin_v_next;
  logic pend_lvl_reg, pend_lvl_next;
  logic det, rise, fall, active, in_mode, out_mode, match_a, match_b, cb_changed;
  logic evt, req, req_lvl;
  logic [31:0] applied;

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;

  // Address and data are taken in either order; the response waits for both
  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (aw_addr_reg > `DACC_PRESC_OFS || aw_addr_reg[1:0] != 2'h0) ?
                   `DACC_RESP_SLVERR : `DACC_RESP_OKAY;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = `DACC_RESP_OKAY;
      case (s_axi_araddr)
        `DACC_CTRL_OFS: rdata_next = {26'h0, ctrl_reg};
        `DACC_DATA_A_OFS: rdata_next = {16'h0, data_a_reg};
        `DACC_DATA_B_OFS: rdata_next = {16'h0, data_b_reg};
        `DACC_STATUS_OFS: rdata_next = {23'h0, sync2_reg, 6'h0, status_reg};
        `DACC_IRQ_CLR_OFS: rdata_next = 32'h0;
        `DACC_IRQ_EN_OFS: rdata_next = {30'h0, en_reg};
        `DACC_PRESC_OFS: rdata_next = {20'h0, psel_reg, cp_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = `DACC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `DACC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `DACC_RESP_OKAY;
      rdata_reg <= 32'h0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Edge detect looks only at the second and third stages
  assign rise = sync2_reg && !sync3_reg;
  assign fall = !sync2_reg && sync3_reg;
  assign det = rise || fall;
  assign active = (ctrl_reg.edge_sel[0] && rise) || (ctrl_reg.edge_sel[1] && fall);
  assign in_mode = ctrl_reg.mode inside {input_capture_mode, input_period_mode,
                                         input_pulse_width_mode};
  assign out_mode = ctrl_reg.mode inside {output_compare_mode, output_pulse_width_mode};
  // Matches count once per new bus value, so compare resolution is the bus step
  assign cb_changed = cbus.value != cb_q_reg.value;
  assign match_a = out_mode && cb_changed && cbus.value == data_a_reg;
  assign match_b = out_mode && cb_changed && cbus.value == data_b_reg;
  assign req = out_mode && (ma_pipe_reg[`DACC_CMP_TO_PIN_CYC-2] ||
               mb_pipe_reg[`DACC_CMP_TO_PIN_CYC-2] || pend_pin_v_reg);

  always_comb begin
    ctrl_next = ctrl_reg;
    data_a_next = data_a_reg;
    data_b_next = data_b_reg;
    en_next = en_reg;
    psel_next = psel_reg;
    cp_next = cp_reg;
    status_next = status_reg;
    act_now = dacc_act_none;
    evt = 1'b0;
    applied = {data_b_reg, data_a_reg};
    if (do_wr) begin
      case (aw_addr_reg)
        `DACC_CTRL_OFS: ctrl_next = dacc_ctrl_t'((`DACC_CTRL_W)'(dacc_merge({26'h0, ctrl_reg},
                                    w_data_reg, w_strb_reg)));
        `DACC_DATA_A_OFS: data_a_next = 16'(dacc_merge({16'h0, data_a_reg}, w_data_reg,
                                                       w_strb_reg));
        `DACC_DATA_B_OFS: data_b_next = 16'(dacc_merge({16'h0, data_b_reg}, w_data_reg,
                                                       w_strb_reg));
        `DACC_IRQ_CLR_OFS: if (w_strb_reg[0]) status_next = status_reg & ~w_data_reg[1:0];
        `DACC_IRQ_EN_OFS: if (w_strb_reg[0]) en_next = w_data_reg[1:0];
        `DACC_PRESC_OFS: begin
          {psel_next, cp_next} = 12'(dacc_merge({20'h0, psel_reg, cp_reg}, w_data_reg,
                                                w_strb_reg));
        end
        default: ;
      endcase
    end
    if (in_mode && det) begin
      case (ctrl_reg.mode)
        input_capture_mode: if (active) act_now = dacc_act_to_a;
        input_period_mode: if (active) act_now = dacc_act_shift;
        input_pulse_width_mode: act_now = rise ? dacc_act_to_b : dacc_act_to_a;
        default: act_now = dacc_act_none;
      endcase
      evt = act_now == dacc_act_to_a || act_now == dacc_act_shift;
    end
    // Hardware capture wins over a software write in the same cycle
    pend_next = dacc_act_none;
    if (pend_reg != dacc_act_none) begin
      applied = dacc_apply(pend_reg, data_a_next, data_b_next, cb_q_reg.value);
      {data_b_next, data_a_next} = applied;
    end
    if (act_now != dacc_act_none) begin
      if (cb_q_reg.upd) begin
        pend_next = act_now;
      end else begin
        applied = dacc_apply(act_now, data_a_next, data_b_next, cb_q_reg.value);
        {data_b_next, data_a_next} = applied;
      end
    end
    if (out_mode && ma_pipe_reg[`DACC_CMP_TO_PIN_CYC-2]) begin
      evt = 1'b1;
    end
    // Set wins over clear
    status_next = status_next | {evt && status_reg[0], evt};
  end

  // Output pin path
  always_comb begin
    ma_pipe_next = {ma_pipe_reg[`DACC_CMP_TO_PIN_CYC-3:0], match_a};
    mb_pipe_next = {mb_pipe_reg[`DACC_CMP_TO_PIN_CYC-3:0], match_b};
    req_lvl = pend_lvl_reg;
    if (ctrl_reg.mode == output_pulse_width_mode) begin
      if (mb_pipe_reg[`DACC_CMP_TO_PIN_CYC-2]) begin
        req_lvl = 1'b0;
      end else if (ma_pipe_reg[`DACC_CMP_TO_PIN_CYC-2]) begin
        req_lvl = 1'b1;
      end
    end else if (ma_pipe_reg[`DACC_CMP_TO_PIN_CYC-2]) begin
      req_lvl = ctrl_reg.out_level;
    end
    pin_out_next = out_mode ? pin_out_reg : 1'b0;
    pend_pin_v_next = 1'b0;
    pend_lvl_next = pend_lvl_reg;
    // A change right after a change is held one cycle to keep pulses two cycles wide
    if (req && pin_chg_reg) begin
      pend_pin_v_next = 1'b1;
      pend_lvl_next = req_lvl;
    end else if (req) begin
      pin_out_next = req_lvl;
    end
    pin_chg_next = pin_out_next != pin_out_reg;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= dacc_ctrl_t'(`DACC_CTRL_RST);
      data_a_reg <= 16'h0;
      data_b_reg <= 16'h0;
      status_reg <= 2'h0;
      en_reg <= 2'h0;
      psel_reg <= `DACC_PSEL_RST;
      cp_reg <= `DACC_CP_RST;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      cb_q_reg <= '0;
      pend_reg <= dacc_act_none;
      ma_pipe_reg <= '0;
      mb_pipe_reg <= '0;
      pin_out_reg <= 1'b0;
      pin_chg_reg <= 1'b0;
      pend_pin_v_reg <= 1'b0;
      pend_lvl_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      data_a_reg <= data_a_next;
      data_b_reg <= data_b_next;
      status_reg <= status_next;
      en_reg <= en_next;
      psel_reg <= psel_next;
      cp_reg <= cp_next;
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      cb_q_reg <= cbus;
      pend_reg <= pend_next;
      ma_pipe_reg <= ma_pipe_next;
      mb_pipe_reg <= mb_pipe_next;
      pin_out_reg <= pin_out_next;
      pin_chg_reg <= pin_chg_next;
      pend_pin_v_reg <= pend_pin_v_next;
      pend_lvl_reg <= pend_lvl_next;
    end
  end
  assign pin_out = pin_out_reg;
  assign pin_oe = out_mode;
  assign prescaler_select_field = psel_reg;
  assign channel_prescale_field = cp_reg;
  assign irq = |(status_reg & en_reg);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_PIN_FOLLOW: assert property (pin_in [*2] |=> sync2_reg)
    else $error("pin status lags the pin too long");
  AST_IN_FLAG: assert property ((in_mode && det && evt) |=> status_reg[0])
    else $error("input flag not set one cycle after detection");
  AST_CAP_STABLE: assert property ((act_now == dacc_act_to_a && !cb_q_reg.upd && !do_wr)
    |=> data_a_reg == $past(cb_q_reg.value))
    else $error("stable bus capture late or wrong");
  AST_CAP_DELAYED: assert property ((act_now == dacc_act_to_a && cb_q_reg.upd)
    |=> pend_reg == dacc_act_to_a ##1 data_a_reg == $past(cb_q_reg.value))
    else $error("postponed capture wrong");
  AST_CMP_PIN: assert property ((ctrl_reg.mode == output_pulse_width_mode && match_a &&
    !match_b && !pin_out_reg && !pin_chg_reg && $stable(ctrl_reg)) |-> ##3 pin_out_reg)
    else $error("pin did not rise three cycles after match");
  AST_CMP_FLAG: assert property ((match_a && ctrl_reg.mode == output_compare_mode)
    |-> ##3 status_reg[0])
    else $error("compare flag not set after three cycles");
  AST_MIN_PULSE: assert property ($changed(pin_out_reg) && out_mode |=> $stable(pin_out_reg))
    else $error("output pulse shorter than two cycles");
  AST_IN_QUIET: assert property ((!out_mode && !$past(out_mode)) |-> !pin_out_reg && !pin_oe)
    else $error("pin driven in an input mode");
  AST_IRQ_LEVEL: assert property (status_reg[0] && en_reg[0] |-> irq)
    else $error("enabled status bit without interrupt");
endmodule : dacc_channel
`default_nettype wire

// [verification/dacc_far_side.sv]
`default_nettype none
module dacc_far_side import dacc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench controls
  input wire logic count_en,
  input wire logic upd_req,
  input wire logic pin_req,
  // Toward the channel
  output logic pin_in,
  output dacc_cbus_t cbus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_reg;
  logic held_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cbus <= '0;
      ph_reg <= 1'b0;
      held_reg <= 1'b0;
      pin_in <= 1'b0;
    end else begin
      ph_reg <= count_en & ~ph_reg;
      cbus.upd <= 1'b0;
      // Steps every second cycle, the finest rate the channel resolves
      if (count_en && ph_reg) begin
        cbus.value <= cbus.value + 16'h1;
        cbus.upd <= upd_req;
      end
      // Never sends a pin phase shorter than two cycles
      held_reg <= 1'b1;
      if (pin_req != pin_in && held_reg) begin
        pin_in <= pin_req;
        held_reg <= 1'b0;
      end
    end
  end
endmodule : dacc_far_side
`default_nettype wire

// [verification/testbench.sv]
`include "dacc_defines.svh"
`default_nettype none
module testbench import dacc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  dacc_cbus_t cbus;
  logic pin_in, pin_out, pin_oe, irq;
  logic [3:0] prescaler_select_field;
  logic [7:0] channel_prescale_field;
  logic count_en = 0, upd_req = 0, pin_req = 0;
  int error_cnt = 0, cmp_count = 0, n;
  logic [31:0] rd, rb;
  logic [1:0] rsp;
  logic [15:0] v, t;
  logic [2:0] md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  always #10 clk_sys = ~clk_sys;

  dacc_channel u_dut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cbus, .pin_in, .pin_out, .pin_oe,
    .prescaler_select_field, .channel_prescale_field, .irq);
  dacc_far_side u_far (.clk_sys, .rst_n, .count_en, .upd_req, .pin_req, .pin_in, .cbus);

  task automatic give_verdict();
    $display("Compares %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang();
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict();
  endtask : hang

  // Both channels offered together; each released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
      if (k > 50) hang();
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk(rsp, `DACC_RESP_OKAY);
    // One idle edge, so a following call never lowers and raises bready in one step
    @(posedge clk_sys);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
      if (k > 50) hang();
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rdr

  // Edges until irq (0), pin_out high (1) or pin_out low (2) is seen
  task automatic until_seen(input int which);
    logic s;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 40) hang();
      s = (which == 0) ? irq : (which == 1) ? pin_out : ~pin_out;
    end while (s !== 1'b1);
  endtask : until_seen

  task automatic set_pin(input logic lvl, input int hold);
    @(posedge clk_sys);
    pin_req <= lvl;
    repeat (hold) @(posedge clk_sys);
  endtask : set_pin

  // Rising edge on the pin; v holds the bus value at the edge
  task automatic rise();
    set_pin(1'b0, 3);
    set_pin(1'b1, 1);
    n = 0;
    while (pin_in !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > 8) hang();
    end
    v = cbus.value;
  endtask : rise

  task automatic wait_bus(input logic [15:0] val);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 40) hang();
    end while (cbus.value !== val);
  endtask : wait_bus

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(prescaler_select_field, 4'h2);
    chk(channel_prescale_field, 8'hff);
    rdr(`DACC_PRESC_OFS);
    chk(rd, 32'h2ff);
    wr(`DACC_PRESC_OFS, 32'h5a7);
    chk(prescaler_select_field, 4'h5);
    chk(channel_prescale_field, 8'ha7);
    wr(`DACC_PRESC_OFS, 32'h2ff);
    rdr(8'h1c);
    chk(rsp, `DACC_RESP_SLVERR);
    chk(rd, 32'h0);
    foreach (md[i]) begin
      wr(`DACC_CTRL_OFS, {29'h0, md[i]});
      rdr(`DACC_CTRL_OFS);
      chk(rd, {29'h0, md[i]});
      chk(pin_oe, md[i][2] & md[i][1]);
    end
    // Capture on a stopped bus, then a second event before any clear
    wr(`DACC_IRQ_EN_OFS, 32'h3);
    wr(`DACC_CTRL_OFS, 32'h11);
    rise();
    until_seen(0);
    chk(n >= 2 && n <= 3, 1);
    rdr(`DACC_DATA_A_OFS);
    chk(rd, {16'h0, v});
    rdr(`DACC_STATUS_OFS);
    chk(rd, 32'h101);
    rise();
    repeat (4) @(posedge clk_sys);
    rdr(`DACC_STATUS_OFS);
    chk(rd, 32'h103);
    wr(`DACC_IRQ_CLR_OFS, 32'h3);
    rdr(`DACC_STATUS_OFS);
    chk(irq, 1'b0);
    chk(rd, 32'h100);
    // Masked event still sets status but keeps irq low
    wr(`DACC_IRQ_EN_OFS, 32'h0);
    rise();
    repeat (4) @(posedge clk_sys);
    rdr(`DACC_STATUS_OFS);
    chk(irq, 1'b0);
    chk(rd, 32'h101);
    wr(`DACC_IRQ_CLR_OFS, 32'h3);
    // Running bus with unsettled cycles: latch lands within a few ticks
    count_en <= 1'b1;
    upd_req <= 1'b1;
    rise();
    repeat (4) @(posedge clk_sys);
    rdr(`DACC_DATA_A_OFS);
    chk(rd[15:0] - v <= 16'h2, 1);
    upd_req <= 1'b0;
    // Period: rising edges eight cycles apart; width: high for six cycles
    wr(`DACC_CTRL_OFS, 32'h12);
    rise();
    set_pin(1'b0, 4);
    set_pin(1'b1, 8);
    rdr(`DACC_DATA_A_OFS);
    rb = rd;
    rdr(`DACC_DATA_B_OFS);
    chk(rb[15:0] - rd[15:0] >= 16'h4 && rb[15:0] - rd[15:0] <= 16'h6, 1);
    wr(`DACC_CTRL_OFS, 32'h33);
    rise();
    set_pin(1'b1, 2);
    set_pin(1'b0, 8);
    rdr(`DACC_DATA_A_OFS);
    rb = rd;
    rdr(`DACC_DATA_B_OFS);
    chk(rb[15:0] - rd[15:0] >= 16'h2 && rb[15:0] - rd[15:0] <= 16'h4, 1);
    // Output compare, pin goes to the stored level
    count_en <= 1'b0;
    wr(`DACC_IRQ_CLR_OFS, 32'h3);
    wr(`DACC_IRQ_EN_OFS, 32'h1);
    t = cbus.value + 16'h4;
    wr(`DACC_DATA_A_OFS, {16'h0, t});
    wr(`DACC_CTRL_OFS, 32'he);
    chk({pin_oe, pin_out, irq}, 3'b100);
    count_en <= 1'b1;
    wait_bus(t);
    until_seen(1);
    chk(n, 3);
    chk(irq, 1'b1);
    // Output pulse: matches one tick apart give the shortest pulse
    count_en <= 1'b0;
    wr(`DACC_CTRL_OFS, 32'h0);
    wr(`DACC_IRQ_CLR_OFS, 32'h3);
    t = cbus.value + 16'h4;
    wr(`DACC_DATA_A_OFS, {16'h0, t});
    wr(`DACC_DATA_B_OFS, {16'h0, t + 16'h1});
    wr(`DACC_CTRL_OFS, 32'h7);
    chk(pin_out, 1'b0);
    count_en <= 1'b1;
    wait_bus(t);
    until_seen(1);
    chk(n, 3);
    until_seen(2);
    chk(n, 2);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
